/* core/sdram_cmd_core.sv */
// Notes on behaviour
// [RQ1] Self refresh keeps only banks chosen by partial-array select; others are lost.
// [RQ2] Selected no-operation takes no command; running bursts carry on.
// [RQ3] Deselected chip ignores all command inputs; running bursts carry on.
// [RQ4] Row, column and write strobes decode into the seven commands.
// [RQ5] Clock enable high for all but self refresh; low turns refresh into entry.
// [RQ6] Activate opens the given row in the given bank until precharge.
// [RQ7] Read and write take column from low address bits; bit 10 asks auto precharge.
// [RQ8] Read lane mask high floats that lane two clocks later.
// [RQ9] Write lane mask sampled with the data word discards that byte.
// [RQ10] Lower mask covers bits 0-7, upper mask bits 8-15.
// [RQ11] Precharge closes one bank, or all banks when bit 10 is high.
// [RQ12] Mode load writes base or extended register by bank select.
// [RQ13] Controller loads mode registers only with all banks idle.
// [RQ14] Auto precharge closes the bank when the burst ends, never for full page.
// [RQ15] Controller waits precharge time after an auto-precharged access.
// [RQ16] Burst terminate stops the latest burst and leaves the row open.
// [RQ17] Controller precharges all banks before auto refresh; row comes from counter.
// [RQ18] Controller supplies 4096 refreshes each 64 ms.
// [RQ19] In self refresh only clock enable is heard; refresh is timed inside.
// [RQ20] Controller holds self refresh at least the row-active minimum.
// [RQ21] Controller gives a stable clock and at least two no-operations on exit.
// [RQ22] Controller refreshes every 15.625 us after leaving self refresh.
module sdram_cmd_core (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic cke,
  input wire logic [1:0] ba,
  input wire logic [11:0] addr,
  input wire logic lower_byte_mask,
  input wire logic upper_byte_mask,
  input wire logic [15:0] dq_in,
  output logic [15:0] dq_out,
  output logic [1:0] dq_oe_n,
  output logic rd_req,
  output sdram_pkg::array_addr_t rd_addr,
  input wire logic [15:0] rd_data,
  output logic wr_valid,
  input wire logic wr_ready,
  output sdram_pkg::wr_word_t wr_word,
  output logic [3:0] bank_open,
  output logic self_refresh,
  output logic refresh_pulse,
  output logic [3:0] refresh_banks,
  output logic [11:0] refresh_row,
  output logic [3:0] lost_banks,
  output logic [10:0] mode_word,
  output logic [10:0] ext_mode_word,
  output logic protocol_err,
  output logic wr_overflow
);
  import sdram_pkg::*;

  typedef struct packed {
    pin_bus_t s1;
    pin_bus_t s2;
    op_state_t state;
    logic [3:0] open;
    logic [3:0][ROW_W-1:0] row;
    logic [10:0] mode;
    logic [10:0] emode;
    logic busy;
    logic wr;
    logic ap;
    logic full;
    logic [1:0] bank;
    logic [COL_W-1:0] col;
    logic [COL_W-1:0] wmask;
    logic [COL_W-1:0] left;
    logic rdv;
    logic [1:0] mq;
    logic [DQ_W-1:0] dq_o;
    logic [1:0] oe_n;
    logic rd_req;
    array_addr_t rd_a;
    logic [ROW_W-1:0] rcnt;
    logic rpulse;
    logic [3:0] rbanks;
    logic [3:0] lost;
    logic perr;
    logic ovf;
  } core_st_t;

  core_st_t st_ff;
  core_st_t nxt_st;
  cmd_t cmd;
  pin_bus_t p;
  logic tick;
  logic push;
  logic fifo_rdy;
  wr_word_t wdata;
  logic [WR_W-1:0] fifo_q;
  logic go;
  logic g_wr;
  logic g_ap;
  logic g_full;
  logic [1:0] g_bank;
  logic [COL_W-1:0] g_col;
  logic [COL_W-1:0] g_left;
  logic [COL_W-1:0] g_wmask;
  logic [COL_W-1:0] blm;

  ////////////////////////////////////////////////////////////////////////////
  // Command decode of the synchronised pins.
  function automatic cmd_t decode(input pin_bus_t q);
    cmd_t c;
    c = CMD_NONE;
    if (!q.cs_n) begin
      case ({q.ras_n, q.cas_n, q.we_n})
        3'b011: c = CMD_ACT;
        3'b101: c = CMD_RD;
        3'b100: c = CMD_WR;
        3'b110: c = CMD_BST;
        3'b010: c = CMD_PRE;
        3'b001: c = q.cke ? CMD_REF : CMD_SREF;
        3'b000: c = CMD_LMR;
        default: c = CMD_NONE;
      endcase
    end
    // Anything other than self-refresh entry needs clock enable high.
    if (!q.cke && c != CMD_SREF) begin
      c = CMD_NONE;
    end
    return c;
  endfunction : decode

  // Banks that survive self refresh for a partial-array selection.
  function automatic logic [3:0] keep_of(input logic [10:0] em);
    logic [2:0] sel;
    sel = em[PARTIAL_ARRAY_REFRESH_SELECT_LSB +: 3];
    if (sel == PARTIAL_ARRAY_REFRESH_SELECT_TWO) begin
      return KEEP_TWO;
    end else if (sel == PARTIAL_ARRAY_REFRESH_SELECT_ONE) begin
      return KEEP_ONE;
    end
    return KEEP_ALL;
  endfunction : keep_of

  ////////////////////////////////////////////////////////////////////////////
  // Sub-blocks: write path buffer towards the array and the self refresh clock.
  wr_fifo #(
    .W(WR_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .in_valid(push),
    .in_ready(fifo_rdy),
    .in_data(wdata),
    .out_valid(wr_valid),
    .out_ready(wr_ready),
    .out_data(fifo_q)
  );

  self_refresh_timer u_timer (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .en(st_ff.state == ST_SREF),
    .tick(tick)
  );

  assign wr_word = wr_word_t'(fifo_q);
  assign p = st_ff.s2;

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic for decode, bank state, bursts and refresh.
  always_comb begin
    nxt_st = st_ff;
    nxt_st.s1 = '{cs_n, ras_n, cas_n, we_n, cke, ba, addr, {upper_byte_mask, lower_byte_mask}, dq_in};
    nxt_st.s2 = st_ff.s1;
    nxt_st.rd_req = 1'b0;
    nxt_st.rdv = 1'b0;
    nxt_st.rpulse = 1'b0;
    push = 1'b0;
    wdata = '0;
    cmd = decode(p); // RQ4 RQ5
    blm = '0;
    case (st_ff.mode[BL_LSB +: 3])
      3'h1: blm = 9'h001;
      3'h2: blm = 9'h003;
      3'h3: blm = 9'h007;
      default: blm = '0;
    endcase
    go = st_ff.busy;
    g_wr = st_ff.wr;
    g_ap = st_ff.ap;
    g_full = st_ff.full;
    g_bank = st_ff.bank;
    g_col = st_ff.col;
    g_left = st_ff.left;
    g_wmask = st_ff.wmask;

    // Lane data and enables are driven from the mask seen two clocks earlier.
    nxt_st.mq = p.byte_mask;
    nxt_st.dq_o = rd_data;
    nxt_st.oe_n = ~({2{st_ff.rdv}} & ~st_ff.mq); // RQ8 RQ10

    if (st_ff.state == ST_SREF) begin
      // Only clock enable is heard; refresh is paced by the local timer.
      if (p.cke) begin
        nxt_st.state = ST_NORMAL; // RQ19
      end
      if (tick) begin
        nxt_st.rpulse = 1'b1;
        nxt_st.rbanks = keep_of(st_ff.emode); // RQ1
        nxt_st.rcnt = st_ff.rcnt + 12'h001;
      end
    end else begin
      // Deselect and no-operation decode to nothing, so a burst just goes on.
      case (cmd) // RQ2 RQ3
        CMD_ACT: begin
          if (st_ff.open[p.ba]) begin
            nxt_st.perr = 1'b1;
          end else begin
            nxt_st.open[p.ba] = 1'b1; // RQ6
            nxt_st.row[p.ba] = p.addr;
          end
        end
        CMD_RD, CMD_WR: begin
          if (!st_ff.open[p.ba]) begin
            nxt_st.perr = 1'b1;
            go = 1'b0;
          end else begin
            // A new access truncates whatever burst was running.
            go = 1'b1;
            g_wr = (cmd == CMD_WR);
            g_bank = p.ba;
            g_col = p.addr[COL_W-1:0]; // RQ7
            g_full = (st_ff.mode[BL_LSB +: 3] == BL_FULL);
            g_ap = p.addr[AP_BIT] && !g_full; // RQ7 RQ14
            g_left = (g_wr && st_ff.mode[WB_SINGLE_BIT]) ? '0 : blm;
            g_wmask = g_full ? 9'h1ff : blm;
          end
        end
        CMD_BST: begin
          go = 1'b0; // RQ16
        end
        CMD_PRE: begin
          if (p.addr[PALL_BIT]) begin
            nxt_st.open = '0; // RQ11
            go = 1'b0;
          end else begin
            nxt_st.open[p.ba] = 1'b0; // RQ11
            go = st_ff.busy && (st_ff.bank != p.ba);
          end
        end
        CMD_REF: begin
          // The row comes from the internal counter, never from the address.
          nxt_st.rpulse = 1'b1;
          nxt_st.rbanks = KEEP_ALL;
          nxt_st.rcnt = st_ff.rcnt + 12'h001;
          if (st_ff.open != '0) begin
            nxt_st.perr = 1'b1;
          end
        end
        CMD_SREF: begin
          nxt_st.state = ST_SREF; // RQ5
          nxt_st.lost = st_ff.lost | ~keep_of(st_ff.emode); // RQ1
          go = 1'b0;
        end
        CMD_LMR: begin
          if (p.ba == SEL_BASE) begin
            nxt_st.mode = p.addr[10:0]; // RQ12
          end else if (p.ba == SEL_EXT) begin
            nxt_st.emode = p.addr[10:0]; // RQ12
          end
        end
        default: begin
        end
      endcase
    end

    // One burst beat per cycle; the column wraps inside its burst block.
    nxt_st.busy = 1'b0;
    if (go) begin
      if (g_wr) begin
        // Mask bits travel with their data word and gate each byte.
        push = 1'b1;
        wdata = '{'{g_bank, st_ff.row[g_bank], g_col}, p.dq, p.byte_mask}; // RQ9 RQ10
        if (!fifo_rdy) begin
          nxt_st.ovf = 1'b1;
        end
      end else begin
        nxt_st.rd_req = 1'b1;
        nxt_st.rdv = 1'b1;
        nxt_st.rd_a = '{g_bank, st_ff.row[g_bank], g_col};
      end
      nxt_st.wr = g_wr;
      nxt_st.ap = g_ap;
      nxt_st.full = g_full;
      nxt_st.bank = g_bank;
      nxt_st.wmask = g_wmask;
      if (g_full || g_left != '0) begin
        nxt_st.busy = 1'b1;
        nxt_st.col = (g_col & ~g_wmask) | ((g_col + 9'h001) & g_wmask);
        nxt_st.left = g_full ? g_left : g_left - 9'h001;
      end else if (g_ap) begin
        nxt_st.open[g_bank] = 1'b0; // RQ14
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register; the pins idle deselected while reset holds.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '0;
      st_ff.s1.cs_n <= 1'b1;
      st_ff.s2.cs_n <= 1'b1;
      st_ff.mode <= MODE_RST;
      st_ff.emode <= EMODE_RST;
      st_ff.oe_n <= OE_OFF;
    end else begin
      st_ff <= nxt_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, each taken from a state flip-flop.
  assign dq_out = st_ff.dq_o;
  assign dq_oe_n = st_ff.oe_n;
  assign rd_req = st_ff.rd_req;
  assign rd_addr = st_ff.rd_a;
  assign bank_open = st_ff.open;
  assign self_refresh = (st_ff.state == ST_SREF);
  assign refresh_pulse = st_ff.rpulse;
  assign refresh_banks = st_ff.rbanks;
  assign refresh_row = st_ff.rcnt;
  assign lost_banks = st_ff.lost;
  assign mode_word = st_ff.mode;
  assign ext_mode_word = st_ff.emode;
  assign protocol_err = st_ff.perr;
  assign wr_overflow = st_ff.ovf;

  ////////////////////////////////////////////////////////////////////////////
  // Checks on decode, bank state, lane masking and self refresh.
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence s_mask_hi_low;
    (st_ff.state == ST_NORMAL) && p.byte_mask[0];
  endsequence

  sequence s_lane_off;
    ##2 dq_oe_n[0];
  endsequence

  property p_nop_holds;
    (st_ff.state == ST_NORMAL && !p.cs_n && p.ras_n && p.cas_n && p.we_n && !st_ff.busy)
      |=> ($stable(bank_open) && $stable(mode_word) && !rd_req);
  endproperty
  a_nop_holds: assert property (p_nop_holds) else $error("nop changed state"); // RQ2

  property p_deselect_holds;
    (st_ff.state == ST_NORMAL && p.cs_n && !st_ff.busy)
      |=> ($stable(bank_open) && $stable(ext_mode_word) && !refresh_pulse);
  endproperty
  a_deselect_holds: assert property (p_deselect_holds) else $error("deselect changed state"); // RQ3

  property p_read_mask;
    s_mask_hi_low |-> s_lane_off;
  endproperty
  a_read_mask: assert property (p_read_mask) else $error("masked lane driven"); // RQ8

  property p_activate;
    (cmd == CMD_ACT && !st_ff.open[p.ba] && st_ff.state == ST_NORMAL)
      |=> (bank_open[$past(p.ba)] && st_ff.row[$past(p.ba)] == $past(p.addr));
  endproperty
  a_activate: assert property (p_activate) else $error("activate did not open row"); // RQ6

  property p_precharge_all;
    (cmd == CMD_PRE && p.addr[PALL_BIT] && st_ff.state == ST_NORMAL) |=> (bank_open == 4'h0);
  endproperty
  a_precharge_all: assert property (p_precharge_all) else $error("banks left open"); // RQ11

  property p_load_base;
    (cmd == CMD_LMR && p.ba == SEL_BASE && st_ff.state == ST_NORMAL) |=> (mode_word == $past(p.addr[10:0]));
  endproperty
  a_load_base: assert property (p_load_base) else $error("base mode not loaded"); // RQ12

  property p_sref_entry;
    (st_ff.state == ST_NORMAL && !p.cs_n && !p.ras_n && !p.cas_n && p.we_n && !p.cke) |=> self_refresh;
  endproperty
  a_sref_entry: assert property (p_sref_entry) else $error("self refresh not entered"); // RQ5

  property p_sref_deaf;
    (self_refresh && !p.cke) |=> (self_refresh && $stable(bank_open) && $stable(mode_word) && !rd_req);
  endproperty
  a_sref_deaf: assert property (p_sref_deaf) else $error("input heard in self refresh"); // RQ19

  property p_partial_array_refresh_select_banks;
    (refresh_pulse && self_refresh) |-> ((refresh_banks & ~keep_of(ext_mode_word)) == 4'h0);
  endproperty
  a_partial_array_refresh_select_banks: assert property (p_partial_array_refresh_select_banks) else $error("unselected bank refreshed"); // RQ1

  property p_terminate;
    (cmd == CMD_BST && st_ff.state == ST_NORMAL) |=> (!st_ff.busy && $stable(bank_open));
  endproperty
  a_terminate: assert property (p_terminate) else $error("terminate misbehaved"); // RQ16

endmodule : sdram_cmd_core

/* core/sdram_pkg.sv */
package sdram_pkg;

  // Clock rate and the distributed refresh interval used during self refresh.
  localparam int CLK_MHZ = 200;
  localparam int REF_INTERVAL_NS = 15625;
  localparam int REF_INTERVAL_CYC = (REF_INTERVAL_NS * CLK_MHZ) / 1000;

  // Geometry of the 16-bit part.
  localparam int DQ_W = 16;
  localparam int ROW_W = 12;
  localparam int COL_W = 9;
  localparam int FIFO_DEPTH = 32;

  // Address bit positions with a special meaning.
  localparam int AP_BIT = 10;
  localparam int PALL_BIT = 10;

  // Base mode register fields: burst length code and write burst mode.
  localparam int BL_LSB = 0;
  localparam int WB_SINGLE_BIT = 9;
  localparam logic [2:0] BL_FULL = 3'h7;

  // Extended mode register field: partial-array selection in bits 2..0.
  localparam int PARTIAL_ARRAY_REFRESH_SELECT_LSB = 0;
  localparam logic [2:0] PARTIAL_ARRAY_REFRESH_SELECT_TWO = 3'h1;
  localparam logic [2:0] PARTIAL_ARRAY_REFRESH_SELECT_ONE = 3'h2;
  localparam logic [3:0] KEEP_ALL = 4'hf;
  localparam logic [3:0] KEEP_TWO = 4'h3;
  localparam logic [3:0] KEEP_ONE = 4'h1;

  // Bank-select codes of the mode register load.
  localparam logic [1:0] SEL_BASE = 2'h0;
  localparam logic [1:0] SEL_EXT = 2'h2;

  // Reset values.
  localparam logic [10:0] MODE_RST = 11'h000;
  localparam logic [10:0] EMODE_RST = 11'h000;
  localparam logic [1:0] OE_OFF = 2'h3;

  typedef enum logic [3:0] {
    CMD_NONE, CMD_ACT, CMD_RD, CMD_WR, CMD_BST, CMD_PRE, CMD_REF, CMD_SREF, CMD_LMR
  } cmd_t;

  typedef enum logic [1:0] {
    ST_NORMAL = 2'b00,
    ST_SREF = 2'b01
  } op_state_t;

  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic cke;
    logic [1:0] ba;
    logic [ROW_W-1:0] addr;
    logic [1:0] byte_mask;
    logic [DQ_W-1:0] dq;
  } pin_bus_t;

  typedef struct packed {
    logic [1:0] bank;
    logic [ROW_W-1:0] row;
    logic [COL_W-1:0] col;
  } array_addr_t;

  typedef struct packed {
    array_addr_t addr;
    logic [DQ_W-1:0] data;
    logic [1:0] byte_mask;
  } wr_word_t;

  localparam int WR_W = $bits(wr_word_t);

endpackage : sdram_pkg

/* core/wr_fifo.sv */
module wr_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 32
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } fifo_st_t;

  fifo_st_t st_ff;
  fifo_st_t nxt_st;
  logic do_in;
  logic do_out;

  ////////////////////////////////////////////////////////////////////////////
  // Full and empty come straight from the occupancy count.
  assign in_ready = (st_ff.cnt != DEPTH[AW:0]);
  assign out_valid = (st_ff.cnt != '0);
  assign out_data = st_ff.mem[st_ff.rp];

  // Pointer and count update; a push and a pop may share a cycle.
  always_comb begin
    nxt_st = st_ff;
    do_in = in_valid && in_ready;
    do_out = out_valid && out_ready;
    if (do_in) begin
      nxt_st.mem[st_ff.wp] = in_data;
      nxt_st.wp = st_ff.wp + 1'b1;
    end
    if (do_out) begin
      nxt_st.rp = st_ff.rp + 1'b1;
    end
    nxt_st.cnt = st_ff.cnt + {{AW{1'b0}}, do_in} - {{AW{1'b0}}, do_out};
  end

  // State register.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

endmodule : wr_fifo

/* core/self_refresh_timer.sv */
module self_refresh_timer (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic en,
  output logic tick
);
  import sdram_pkg::*;

  typedef struct packed {
    logic [11:0] cnt;
    logic tick;
  } tmr_st_t;

  tmr_st_t st_ff;
  tmr_st_t nxt_st;

  ////////////////////////////////////////////////////////////////////////////
  // Free-running interval counter while enabled; restarts on every entry.
  always_comb begin
    nxt_st = st_ff;
    nxt_st.tick = 1'b0;
    if (!en) begin
      nxt_st.cnt = '0;
    end else if (st_ff.cnt == 12'(REF_INTERVAL_CYC - 1)) begin
      nxt_st.cnt = '0;
      nxt_st.tick = 1'b1;
    end else begin
      nxt_st.cnt = st_ff.cnt + 12'h001;
    end
  end

  // State register.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign tick = st_ff.tick;

endmodule : self_refresh_timer

/* sim/array_model.sv */
module array_model (
  input wire logic clk_sys,
  input wire logic rd_req,
  input wire sdram_pkg::array_addr_t rd_addr,
  output logic [15:0] rd_data,
  input wire logic wr_valid,
  output logic wr_ready,
  input wire sdram_pkg::wr_word_t wr_word,
  input wire logic stall
);
  timeunit 1ns;
  timeprecision 1ps;
  import sdram_pkg::*;

  logic [15:0] mem [logic [22:0]];
  logic [15:0] old;

  // Unwritten places read back a pattern built from their own address.
  function automatic logic [15:0] look(input array_addr_t a);
    return mem.exists(a) ? mem[a] : {a.bank, a.col, a.row[4:0]};
  endfunction : look

  ////////////////////////////////////////////////////////////////////////////////
  // The bench may stall the array so that the write queue fills up.
  assign wr_ready = ~stall;

  initial rd_data = 16'h5a5a;

  // Reads answer inside the cycle in which the request stands, so the core takes them at the next rising edge.
  // An idle data bus toggles so a stale value never passes.
  always @(negedge clk_sys) begin
    rd_data <= rd_req ? look(rd_addr) : ~rd_data;
  end

  // Writes land at the rising edge at which the queue head is taken.
  always @(posedge clk_sys) begin
    old = look(wr_word.addr);
    if (wr_valid && wr_ready) begin
      mem[wr_word.addr] = {wr_word.byte_mask[1] ? old[15:8] : wr_word.data[15:8],
                           wr_word.byte_mask[0] ? old[7:0] : wr_word.data[7:0]};
    end
  end
endmodule : array_model

/* sim/sdram_command_refresh_logic_test.sv */
module sdram_command_refresh_logic_test;
  timeunit 1ns;
  timeprecision 1ps;
  import sdram_pkg::*;

  localparam logic [3:0] NOP = 4'h7, ACT = 4'h3, RD = 4'h5, WR = 4'h4, BST = 4'h6;
  localparam logic [3:0] PRE = 4'h2, REF = 4'h1, LMR = 4'h0, DES = 4'h8;

  logic clk_sys = 0, rst_n = 0, cs_n = 1, ras_n = 1, cas_n = 1, we_n = 1, cke = 1, stall = 0;
  logic lower_byte_mask = 0, upper_byte_mask = 0;
  logic [1:0] ba = 0, dq_oe_n;
  logic [11:0] addr = 0, refresh_row;
  logic [15:0] dq_in = 0, dq_out, rd_data;
  logic rd_req, wr_valid, wr_ready, self_refresh, refresh_pulse, protocol_err, wr_overflow;
  array_addr_t rd_addr;
  wr_word_t wr_word;
  logic [3:0] bank_open, refresh_banks, lost_banks, last_banks;
  logic [10:0] mode_word, ext_mode_word;
  logic [17:0] beats[$];
  logic [3:0] lost_exp[3] = '{4'h0, 4'hc, 4'he};
  logic [3:0] keep_exp[3] = '{4'hf, 4'h3, 4'h1};
  int fails = 0, checked = 0, pulses = 0, prev;

  ////////////////////////////////////////////////////////////////////////////////
  sdram_cmd_core dut (.clk_sys, .rst_n, .cs_n, .ras_n, .cas_n, .we_n, .cke, .ba, .addr,
    .lower_byte_mask, .upper_byte_mask, .dq_in, .dq_out, .dq_oe_n, .rd_req, .rd_addr, .rd_data,
    .wr_valid, .wr_ready, .wr_word, .bank_open, .self_refresh, .refresh_pulse, .refresh_banks,
    .refresh_row, .lost_banks, .mode_word, .ext_mode_word, .protocol_err, .wr_overflow);

  array_model array (.clk_sys, .rd_req, .rd_addr, .rd_data, .wr_valid, .wr_ready, .wr_word, .stall);

  initial forever #2.5 clk_sys = ~clk_sys;

  // Collect driven read beats with floating lanes zeroed, and count refresh pulses.
  always @(posedge clk_sys) begin
    if (dq_oe_n !== 2'b11) begin
      beats.push_back({dq_oe_n, dq_out[15:8] & {8{~dq_oe_n[1]}}, dq_out[7:0] & {8{~dq_oe_n[0]}}});
    end
    if (refresh_pulse === 1'b1) begin
      pulses++;
      last_banks = refresh_banks;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : tick

  // Places one command on the pins for a single cycle, then returns to no-operation.
  task automatic cmd(input logic [3:0] c, input logic [1:0] b, input logic [11:0] a);
    @(negedge clk_sys);
    {cs_n, ras_n, cas_n, we_n} = c;
    ba = b;
    addr = a;
    @(negedge clk_sys);
    {cs_n, ras_n, cas_n, we_n} = NOP;
  endtask : cmd

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Reads a burst and compares each beat with the column order wrapping inside the block.
  task automatic rd_burst(input logic [1:0] b, input logic [4:0] r, input logic [11:0] a, input int bl,
                          input int n);
    logic [8:0] c;
    logic [15:0] e;
    beats.delete();
    cmd(RD, b, a);
    tick(n + 8);
    chk(beats.size(), n);
    for (int k = 0; k < n; k++) begin
      c = (a[8:0] & ~9'(bl - 1)) | ((a[8:0] + 9'(k)) & 9'(bl - 1));
      e = {b, c, r};
      chk(beats[k], {1'b0, lower_byte_mask, e[15:8], e[7:0] & {8{~lower_byte_mask}}});
    end
  endtask : rd_burst

  task automatic summarize();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : summarize

  ////////////////////////////////////////////////////////////////////////////////
  // A hang is cut short well after the whole sequence should have ended.
  initial begin
    #200us;
    fails++;
    summarize();
  end

  // Main sequence of command scenarios.
  initial begin
    repeat (16) @(negedge clk_sys);
    rst_n = 1;
    tick(2);
    chk({dq_oe_n, bank_open, self_refresh, protocol_err, wr_valid, mode_word}, {2'b11, 18'h0});
    cmd(LMR, 2'd0, 12'h002);
    cmd(LMR, 2'd2, 12'h001);
    cmd(LMR, 2'd1, 12'h7ff);
    cmd(LMR, 2'd3, 12'h7ff);
    cmd(DES, 2'd0, 12'h055);
    cke = 0;
    cmd(LMR, 2'd0, 12'h055);
    tick(3);
    cke = 1;
    chk({mode_word, ext_mode_word}, {11'h002, 11'h001});
    cmd(ACT, 2'd1, 12'h005);
    tick(3);
    chk(bank_open, 4'h2);
    rd_burst(2'd1, 5'd5, 12'h002, 4, 4);
    lower_byte_mask = 1;
    rd_burst(2'd1, 5'd5, 12'h005, 4, 4);
    lower_byte_mask = 0;
    rd_burst(2'd1, 5'd5, 12'h401, 4, 4);
    chk(bank_open, 4'h0);
    cmd(LMR, 2'd0, 12'h000);
    cmd(ACT, 2'd3, 12'h009);
    dq_in = 16'habcd;
    upper_byte_mask = 1;
    cmd(WR, 2'd3, 12'h004);
    tick(2);
    upper_byte_mask = 0;
    tick(8);
    beats.delete();
    cmd(RD, 2'd3, 12'h004);
    tick(9);
    chk(beats[0], 18'h0c0cd);
    cmd(ACT, 2'd1, 12'h005);
    cmd(PRE, 2'd3, 12'h000);
    tick(3);
    chk(bank_open, 4'h2);
    cmd(PRE, 2'd0, 12'h400);
    tick(3);
    chk({protocol_err, bank_open}, 5'h00);
    cmd(RD, 2'd0, 12'h000);
    tick(3);
    chk({protocol_err, bank_open}, 5'h10);
    cmd(LMR, 2'd0, 12'h007);
    cmd(ACT, 2'd2, 12'h003);
    beats.delete();
    cmd(RD, 2'd2, 12'h1fe);
    tick(1);
    cmd(BST, 2'd0, 12'h000);
    tick(10);
    chk({beats.size() inside {[3:5]}, beats[2]}, {1'b1, 2'b00, 2'd2, 9'd0, 5'd3});
    stall = 1;
    dq_in = 16'h1234;
    cmd(WR, 2'd2, 12'h400);
    tick(40);
    cmd(BST, 2'd0, 12'h000);
    tick(4);
    chk({wr_overflow, wr_valid, bank_open}, {2'b11, 4'h4});
    stall = 0;
    tick(40);
    chk(wr_valid, 0);
    cmd(PRE, 2'd0, 12'h400);
    tick(4);
    prev = pulses;
    cmd(REF, 2'd0, 12'h000);
    tick(4);
    chk({16'(pulses - prev), last_banks, refresh_row}, {16'h1, 4'hf, 12'h001});
    for (int i = 0; i < 3; i++) begin
      cmd(LMR, 2'd2, 12'(i));
      cke = 0;
      cmd(REF, 2'd0, 12'h000);
      tick(3);
      chk({self_refresh, lost_banks}, {1'b1, lost_exp[i]});
      prev = pulses;
      cmd(ACT, 2'd0, 12'h000);
      tick(3200);
      chk({pulses > prev, last_banks, bank_open}, {1'b1, keep_exp[i], 4'h0});
      cke = 1;
      tick(4);
      chk(self_refresh, 0);
    end
    prev = pulses;
    cmd(REF, 2'd0, 12'h000);
    tick(4);
    chk({16'(pulses - prev), last_banks, refresh_row}, {16'h1, 4'hf, 12'h005});
    summarize();
  end
endmodule : sdram_command_refresh_logic_test
